/* File: include/keypad_lock_map.svh */
// constants and register map of the keypad code lock
// Behaviour
// - four digits in order within entry window
// - arm code latches lock low, pulses arm
// - arm code defaults to keys 0 1 5 4
// - disarm code latches lock high, pulses disarm
// - disarm shares first three digits with arm
// - identical arm and disarm codes toggle lock
// - disarm defaults to keys 0 1 5 0
// - duress unlocks, pulses disarm, latches alarm
// - duress alarm only if fourth digit differs
// - duress defaults to keys 0 1 5 1
// - disarm code then key C twice enters programming
// - no entry timeout while programming
// - six digits program all three codes
// - scan, debounce, one event per closure
// - wrong key pulses tamper outside programming
// - wrong key resets timer and digit pointer
// - one pulse width setting for all pulses
// - pulses on every correct entry
// - alarm holds until next arm code
// - lock status is complement of lock
// - entry limit bounds code, not the six digits for programming
`ifndef KEYPAD_LOCK_MAP_SVH
`define KEYPAD_LOCK_MAP_SVH

`define KL_CLK_HZ 50000000
`define KL_SCAN_HZ 10000
`define KL_DEB_MS 25
`define KL_ENTRY_MS 5000
`define KL_PULSE_MS 100

// key code is {sense index, drive index}
`define KL_KEY_PROG 4'hC
`define KL_KEY_REDO 4'hE
// slots: 0..2 common, 3 arm, 4 disarm, 5 duress
`define KL_CODE_DEF 24'h104510

`define KL_REG_ENTRY 4'h0
`define KL_REG_PULSE 4'h4
`define KL_REG_STATUS 4'h8
`define KL_REG_CODES 4'hC

`define KL_ST_LOCK 0
`define KL_ST_ALARM 1
`define KL_ST_PROG 2
`define KL_ST_PTR 3

`endif

/* File: include/keypad_lock_pkg.sv */
// types of the keypad code lock
package keypad_lock_pkg;

  typedef enum logic [1:0] {
    SC_SEEK = 2'b00,
    SC_DEB = 2'b01,
    SC_HELD = 2'b10,
    SC_REL = 2'b11
  } scan_t;

  typedef enum logic [1:0] {
    MD_CODE = 2'b00,
    MD_WAIT = 2'b01,
    MD_PROG = 2'b10
  } mode_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } avs_rsp_t;

  typedef struct packed {
    logic [15:0] div;
    logic [1:0] row;
    logic [3:0] oe;
    scan_t scan;
    logic [3:0] key;
    logic [15:0] deb;
    mode_t mode;
    logic [2:0] ptr;
    logic pcount;
    logic [15:0] tmr;
    logic [15:0] pcnt;
    logic arm_p;
    logic dis_p;
    logic tmp_p;
    logic lock;
    logic lock_n;
    logic alarm;
    logic prog;
    logic [5:0][3:0] code;
    logic [5:0][3:0] stage;
    logic [15:0] entry_lim;
    logic [15:0] pulse_lim;
    logic ack;
    avs_rsp_t rsp;
  } core_t;

endpackage

/* File: hw/keypad_code_lock.sv */
// keypad scanner, code checker and lock outputs with avalon registers
`timescale 1ns/1ps
`include "keypad_lock_map.svh"

module keypad_code_lock
  import keypad_lock_pkg::*;
#(
  parameter int CLK_HZ = `KL_CLK_HZ,
  parameter int SCAN_HZ = `KL_SCAN_HZ,
  parameter int SCAN_DIV = CLK_HZ / SCAN_HZ,
  parameter int DEB_TICKS = (`KL_DEB_MS * SCAN_HZ + 999) / 1000,
  parameter int ENTRY_TICKS = (`KL_ENTRY_MS * SCAN_HZ) / 1000,
  parameter int PULSE_TICKS = (`KL_PULSE_MS * SCAN_HZ) / 1000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // avalon slave
  input wire avs_req_t avs_req_i,
  output avs_rsp_t avs_rsp_o,
  // keypad matrix
  input wire logic [3:0] key_sense_i,
  output logic [3:0] key_drive_o,
  output logic [3:0] key_drive_oe_o,
  // lock outputs
  output logic lock_o,
  output logic lock_status_o,
  output logic alarm_o,
  output logic prog_o,
  output logic arm_pulse_o,
  output logic disarm_pulse_o,
  output logic tamper_o
);

  localparam logic [15:0] DIV_END = 16'(SCAN_DIV - 1);
  localparam logic [15:0] DEB_END = 16'(DEB_TICKS);
  localparam logic [15:0] ENTRY_DEF = 16'(ENTRY_TICKS);
  localparam logic [15:0] PULSE_DEF = 16'(PULSE_TICKS);

  core_t s_q;
  core_t s_d;

  ////////////////////////////////////////////////////////////////
  // helpers

  // lowest closed sense line, bit 2 flags a closure
  function automatic logic [2:0] first_low(input logic [3:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (!v[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] row_hot(input logic [1:0] r);
    return 4'h1 << r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // next state

  logic tick;
  logic [2:0] hit;
  logic evt;
  logic [3:0] k;
  logic is_arm;
  logic is_dis;
  logic is_dur;
  logic bad;
  logic [2:0] p;
  logic expired;
  mode_t m;

  always_comb begin
    s_d = s_q;
    tick = 1'b0;
    evt = 1'b0;
    k = 4'h0;
    is_arm = 1'b0;
    is_dis = 1'b0;
    is_dur = 1'b0;
    bad = 1'b0;
    expired = 1'b0;
    p = s_q.ptr;
    hit = first_low(key_sense_i);

    // scan prescaler
    if (s_q.div >= DIV_END) begin
      s_d.div = 16'h0000;
      tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 16'h0001;
    end

    // scan and debounce
    case (s_q.scan)
      SC_SEEK: begin
        if (tick) begin
          if (hit[2]) begin
            s_d.scan = SC_DEB;
            s_d.key = {hit[1:0], s_q.row};
            s_d.deb = 16'h0000;
          end else begin
            s_d.row = s_q.row + 2'h1;
          end
        end
      end
      SC_DEB: begin
        if (tick) begin
          if (!hit[2] || hit[1:0] != s_q.key[3:2]) begin
            s_d.scan = SC_SEEK;
          end else if (s_q.deb + 16'h0001 >= DEB_END) begin
            s_d.scan = SC_HELD;
            evt = 1'b1;
          end else begin
            s_d.deb = s_q.deb + 16'h0001;
          end
        end
      end
      SC_HELD: begin
        if (tick && !hit[2]) begin
          s_d.scan = SC_REL;
          s_d.deb = 16'h0000;
        end
      end
      SC_REL: begin
        if (tick) begin
          if (hit[2]) begin
            s_d.scan = SC_HELD;
          end else if (s_q.deb + 16'h0001 >= DEB_END) begin
            s_d.scan = SC_SEEK;
          end else begin
            s_d.deb = s_q.deb + 16'h0001;
          end
        end
      end
      default: begin
        s_d.scan = SC_SEEK;
      end
    endcase
    s_d.oe = row_hot(s_d.row);

    // pulse width counter
    if (tick && s_q.pcnt != 16'h0000) begin
      s_d.pcnt = s_q.pcnt - 16'h0001;
      if (s_q.pcnt == 16'h0001) begin
        s_d.arm_p = 1'b0;
        s_d.dis_p = 1'b0;
        s_d.tmp_p = 1'b0;
      end
    end

    // entry window, stopped while programming
    if (s_q.mode == MD_WAIT || (s_q.mode == MD_CODE && s_q.ptr != 3'h0))
    begin
      if (tick) begin
        s_d.tmr = s_q.tmr + 16'h0001;
        if (s_q.tmr + 16'h0001 >= s_q.entry_lim) begin
          expired = 1'b1;
          s_d.mode = MD_CODE;
          s_d.ptr = 3'h0;
          s_d.tmr = 16'h0000;
        end
      end
    end else begin
      s_d.tmr = 16'h0000;
    end

    // a key on the expiry tick starts a fresh entry
    m = s_q.mode;
    if (expired) begin
      m = MD_CODE;
      p = 3'h0;
    end

    // key event handling
    if (evt) begin
      k = s_q.key;
      case (m)
        MD_PROG: begin
          if (k == `KL_KEY_REDO) begin
            s_d.ptr = 3'h0;
          end else begin
            s_d.stage[s_q.ptr] = k;
            s_d.ptr = s_q.ptr + 3'h1;
            if (s_q.ptr == 3'h5) begin
              s_d.code = s_d.stage;
              s_d.prog = 1'b0;
              s_d.mode = MD_CODE;
              s_d.ptr = 3'h0;
            end
          end
        end
        default: begin
          if (m == MD_WAIT && k == `KL_KEY_PROG) begin
            s_d.pcount = 1'b1;
            if (s_q.pcount) begin
              s_d.mode = MD_PROG;
              s_d.prog = 1'b1;
              s_d.ptr = 3'h0;
            end
          end else begin
            if (m == MD_WAIT) begin
              p = 3'h0;
              s_d.tmr = 16'h0000;
            end
            s_d.mode = MD_CODE;
            if (p < 3'h3) begin
              if (k == s_q.code[p]) begin
                s_d.ptr = p + 3'h1;
              end else begin
                bad = 1'b1;
              end
            end else begin
              is_arm = k == s_q.code[3];
              is_dis = k == s_q.code[4];
              is_dur = k == s_q.code[5] && !is_arm && !is_dis;
              s_d.ptr = 3'h0;
              s_d.tmr = 16'h0000;
              if (is_arm && is_dis) begin
                s_d.lock = !s_q.lock;
                s_d.pcnt = s_q.pulse_lim;
                s_d.arm_p = s_q.lock;
                s_d.dis_p = !s_q.lock;
                s_d.tmp_p = 1'b0;
                if (s_q.lock) begin
                  s_d.alarm = 1'b0;
                end
                s_d.mode = MD_WAIT;
                s_d.pcount = 1'b0;
              end else if (is_arm) begin
                s_d.lock = 1'b0;
                s_d.alarm = 1'b0;
                s_d.pcnt = s_q.pulse_lim;
                s_d.arm_p = 1'b1;
                s_d.dis_p = 1'b0;
                s_d.tmp_p = 1'b0;
              end else if (is_dis) begin
                s_d.lock = 1'b1;
                s_d.pcnt = s_q.pulse_lim;
                s_d.arm_p = 1'b0;
                s_d.dis_p = 1'b1;
                s_d.tmp_p = 1'b0;
                s_d.mode = MD_WAIT;
                s_d.pcount = 1'b0;
              end else if (is_dur) begin
                s_d.lock = 1'b1;
                s_d.alarm = 1'b1;
                s_d.pcnt = s_q.pulse_lim;
                s_d.arm_p = 1'b0;
                s_d.dis_p = 1'b1;
                s_d.tmp_p = 1'b0;
              end else begin
                bad = 1'b1;
              end
            end
            if (bad) begin
              s_d.pcnt = s_q.pulse_lim;
              s_d.arm_p = 1'b0;
              s_d.dis_p = 1'b0;
              s_d.tmp_p = 1'b1;
              s_d.ptr = 3'h0;
              s_d.tmr = 16'h0000;
            end
          end
        end
      endcase
    end
    s_d.lock_n = !s_d.lock;

    // avalon slave, one wait cycle then one ready cycle
    if (s_q.ack) begin
      s_d.ack = 1'b0;
      s_d.rsp.waitrequest = 1'b1;
      if (avs_req_i.write) begin
        case (avs_req_i.address)
          `KL_REG_ENTRY: begin
            s_d.entry_lim = avs_req_i.writedata[15:0];
          end
          `KL_REG_PULSE: begin
            s_d.pulse_lim = avs_req_i.writedata[15:0];
          end
          default: begin
          end
        endcase
      end
    end else if (avs_req_i.read || avs_req_i.write) begin
      s_d.ack = 1'b1;
      s_d.rsp.waitrequest = 1'b0;
      s_d.rsp.readdata = 32'h0000_0000;
      if (avs_req_i.read) begin
        case (avs_req_i.address)
          `KL_REG_ENTRY: begin
            s_d.rsp.readdata[15:0] = s_q.entry_lim;
          end
          `KL_REG_PULSE: begin
            s_d.rsp.readdata[15:0] = s_q.pulse_lim;
          end
          `KL_REG_STATUS: begin
            s_d.rsp.readdata[`KL_ST_LOCK] = s_q.lock;
            s_d.rsp.readdata[`KL_ST_ALARM] = s_q.alarm;
            s_d.rsp.readdata[`KL_ST_PROG] = s_q.prog;
            s_d.rsp.readdata[`KL_ST_PTR +: 3] = s_q.ptr;
          end
          `KL_REG_CODES: begin
            s_d.rsp.readdata[23:0] = s_q.code;
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q.div <= 16'h0000;
      s_q.row <= 2'h0;
      s_q.oe <= 4'h1;
      s_q.scan <= SC_SEEK;
      s_q.key <= 4'h0;
      s_q.deb <= 16'h0000;
      s_q.mode <= MD_CODE;
      s_q.ptr <= 3'h0;
      s_q.pcount <= 1'b0;
      s_q.tmr <= 16'h0000;
      s_q.pcnt <= 16'h0000;
      s_q.arm_p <= 1'b0;
      s_q.dis_p <= 1'b0;
      s_q.tmp_p <= 1'b0;
      s_q.lock <= 1'b0;
      s_q.lock_n <= 1'b1;
      s_q.alarm <= 1'b0;
      s_q.prog <= 1'b0;
      s_q.code <= `KL_CODE_DEF;
      s_q.stage <= `KL_CODE_DEF;
      s_q.entry_lim <= ENTRY_DEF;
      s_q.pulse_lim <= PULSE_DEF;
      s_q.ack <= 1'b0;
      s_q.rsp <= '{waitrequest: 1'b1, readdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign avs_rsp_o = s_q.rsp;
  assign key_drive_o = 4'h0;
  assign key_drive_oe_o = s_q.oe;
  assign lock_o = s_q.lock;
  assign lock_status_o = s_q.lock_n;
  assign alarm_o = s_q.alarm;
  assign prog_o = s_q.prog;
  assign arm_pulse_o = s_q.arm_p;
  assign disarm_pulse_o = s_q.dis_p;
  assign tamper_o = s_q.tmp_p;

endmodule

/* File: tb/keypad_model.sv */
// keypad matrix model with pulled-up sense lines
`timescale 1ns/1ps
module keypad_model (
  // rows driven low by the lock
  input wire logic [3:0] key_drive_oe_i,
  // key to close, {sense, drive}
  input wire logic [3:0] key_i,
  input wire logic press_i,
  // sense lines
  output logic [3:0] key_sense_o
);
  always_comb begin
    key_sense_o = 4'hF;
    if (press_i && key_drive_oe_i[key_i[1:0]]) begin
      key_sense_o[key_i[3:2]] = 1'b0;
    end
  end
endmodule

/* File: tb/keypad_lock_asserts.sv */
// assertions on the ports of the keypad code lock
`timescale 1ns/1ps
module keypad_lock_asserts #(
  parameter int SCAN_DIV = 4,
  parameter int PULSE_TICKS = 5
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] key_drive_o,
  input wire logic [3:0] key_drive_oe_o,
  input wire logic lock_o,
  input wire logic lock_status_o,
  input wire logic alarm_o,
  input wire logic prog_o,
  input wire logic arm_pulse_o,
  input wire logic disarm_pulse_o,
  input wire logic tamper_o
);
  localparam int LO = (PULSE_TICKS - 1) * SCAN_DIV;
  localparam int HI = (PULSE_TICKS + 1) * SCAN_DIV;
  logic any_p;
  logic [15:0] pw_q;
  assign any_p = arm_pulse_o | disarm_pulse_o | tamper_o;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pw_q <= 16'h0000;
    end else begin
      pw_q <= any_p ? pw_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_arm;
    $rose(arm_pulse_o);
  endsequence
  sequence s_dis;
    $rose(disarm_pulse_o);
  endsequence
  a_status_inverse: assert property (lock_status_o == !lock_o)
    else $error("lock status");
  a_arm_locks: assert property (s_arm |-> !lock_o && !alarm_o)
    else $error("arm");
  a_disarm_opens: assert property (s_dis |-> lock_o)
    else $error("disarm");
  a_lock_cause: assert property ($changed(lock_o) |->
    $rose(arm_pulse_o) || $rose(disarm_pulse_o)) else $error("lock cause");
  a_alarm_set: assert property ($rose(alarm_o) |-> s_dis)
    else $error("alarm set");
  a_alarm_clear: assert property ($fell(alarm_o) |-> s_arm)
    else $error("alarm clear");
  a_pulse_width: assert property ($fell(any_p) |->
    pw_q >= LO && pw_q <= HI) else $error("pulse width");
  a_pulse_single: assert property (
    $onehot0({arm_pulse_o, disarm_pulse_o, tamper_o})) else $error("pulses");
  a_scan_row: assert property (
    $onehot(key_drive_oe_o) && key_drive_o == 4'h0) else $error("scan");
  a_prog_quiet: assert property (prog_o |->
    !$rose(tamper_o) && $stable(lock_o)) else $error("program");
endmodule
bind keypad_code_lock keypad_lock_asserts #(
  .SCAN_DIV(SCAN_DIV), .PULSE_TICKS(PULSE_TICKS)
) keypad_lock_asserts_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .key_drive_o(key_drive_o),
  .key_drive_oe_o(key_drive_oe_o), .lock_o(lock_o),
  .lock_status_o(lock_status_o), .alarm_o(alarm_o), .prog_o(prog_o),
  .arm_pulse_o(arm_pulse_o), .disarm_pulse_o(disarm_pulse_o),
  .tamper_o(tamper_o)
);

/* File: tb/tb_top.sv */
// self-checking bench of the keypad code lock
`timescale 1ns/1ps
module tb_top;
  import keypad_lock_pkg::*;
  logic clk_i, rst_b_i, press, clr, lock, lst, alarm, prog;
  logic arm_p, dis_p, tmp_p;
  logic [3:0] sense, oe, key;
  logic [2:0] seen;
  logic [31:0] rd;
  avs_req_t req;
  avs_rsp_t rsp;
  int failures, num_checks;
  // rows: four keys, expected {lock, alarm, arm, disarm, tamper}
  logic [15:0] r_key [7] = '{16'h4510, 16'h0510, 16'h0510, 16'h1510,
    16'h4510, 16'hF510, 16'h1504};
  logic [4:0] r_exp [7] = '{5'h04, 5'h12, 5'h12, 5'h1A, 5'h04, 5'h01,
    5'h01};
  keypad_code_lock #(.SCAN_DIV(4), .DEB_TICKS(3), .ENTRY_TICKS(200),
    .PULSE_TICKS(5)) keypad_code_lock_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_req_i(req), .avs_rsp_o(rsp),
    .key_sense_i(sense), .key_drive_o(), .key_drive_oe_o(oe),
    .lock_o(lock), .lock_status_o(lst), .alarm_o(alarm), .prog_o(prog),
    .arm_pulse_o(arm_p), .disarm_pulse_o(dis_p), .tamper_o(tmp_p));
  keypad_model keypad_model_inst (.key_drive_oe_i(oe), .key_i(key),
    .press_i(press), .key_sense_o(sense));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (!rst_b_i || clr) begin
      seen <= 3'h0;
    end else begin
      seen <= seen | {arm_p, dis_p, tmp_p};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    @(posedge clk_i);
    while (rsp.waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        failures++;
        $display("mismatch at %0t: bus timeout", $time);
        stop_test();
      end
      @(posedge clk_i);
    end
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic out(input logic l, input logic a, input logic [2:0] p);
    check({lock, lst, alarm, seen}, {l, !l, a, p});
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  task automatic hit(input logic [3:0] k, input int n);
    key <= k;
    press <= 1'b1;
    repeat (n) @(posedge clk_i);
    press <= 1'b0;
    repeat (48) @(posedge clk_i);
  endtask
  task automatic seq(input logic [23:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      hit(s[4*i +: 4], 48);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b_i = 1'b0;
    req = '0;
    key = 4'h0;
    press = 1'b0;
    clr = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    out(1'b0, 1'b0, 3'h0);
    rchk(4'h0, 32'hC8);
    rchk(4'h4, 32'h5);
    rchk(4'hC, 32'h104510);
    bus(1'b1, 4'h8, 32'hFF);
    rchk(4'h8, 32'h0);
    rchk(4'h6, 32'h0);
    bus(1'b1, 4'h0, 32'h190);
    rchk(4'h0, 32'h190);
    bus(1'b1, 4'h0, 32'hC8);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      seq(24'(r_key[i]), 4);
      out(r_exp[i][4], r_exp[i][3], r_exp[i][2:0]);
      $display("row %0d done", i);
    end
    hit(4'hF, 8);
    out(1'b0, 1'b0, 3'h0);
    hit(4'h0, 400);
    rchk(4'h8, 32'h8);
    repeat (800) @(posedge clk_i);
    rchk(4'h8, 32'h0);
    seq(24'hF10, 3);
    rchk(4'h8, 32'h0);
    out(1'b0, 1'b0, 3'h1);
    $display("key test done");
    seq(24'hCC0510, 6);
    rchk(4'h8, 32'h5);
    check(32'(prog), 32'h1);
    out(1'b1, 1'b0, 3'h2);
    repeat (1000) @(posedge clk_i);
    seq(24'h32, 2);
    rchk(4'h8, 32'h15);
    hit(4'hE, 48);
    rchk(4'h8, 32'h5);
    seq(24'h987632, 6);
    rchk(4'h8, 32'h1);
    check(32'(prog), 32'h0);
    rchk(4'hC, 32'h987632);
    out(1'b1, 1'b0, 3'h0);
    seq(24'h7632, 4);
    out(1'b0, 1'b0, 3'h4);
    seq(24'hCC8632, 6);
    seq(24'h977632, 6);
    out(1'b1, 1'b0, 3'h2);
    seq(24'h7632, 4);
    out(1'b0, 1'b0, 3'h4);
    seq(24'h7632, 4);
    out(1'b1, 1'b0, 3'h2);
    $display("program test done");
    stop_test();
  end
endmodule
